// *** hw/irqsp_pkg.sv ***
/*
 * irqsp_pkg: constants, state layout and pin bundle of the priority
 * interrupt controller (status readback, poll, cascade).
 * Assumes one 25 MHz clock and a synchronous active-high reset.
 */
package irqsp_pkg;

    // unit placement in the four-port window (low bit = register select)
    localparam logic [1:0] PORT_OFS_MASTER_LOW  = 2'h0;
    localparam logic [1:0] PORT_OFS_MASTER_HIGH = 2'h1;
    localparam logic [1:0] PORT_OFS_SLAVE_LOW   = 2'h2;
    localparam logic [1:0] PORT_OFS_SLAVE_HIGH  = 2'h3;
    localparam int         PORT_UNIT_BIT        = 1;
    localparam int         PORT_SEL_BIT         = 0;

    // master input that carries the on-card slave
    localparam logic [2:0] ONBOARD_SLAVE_LEVEL  = 3'h1;

    // command byte fields at the low address
    localparam int CMD_INIT_BIT     = 4;
    localparam int CMD_OPER_BIT     = 3;
    localparam int CMD_POLL_BIT     = 2;
    localparam int CMD_RSEL_EN_BIT  = 1;
    localparam int CMD_RSEL_ISR_BIT = 0;
    localparam int CMD_EOI_BIT      = 5;
    localparam int CMD_SPEC_BIT     = 6;
    localparam int INIT_LEVEL_BIT   = 3;

    // mode byte fields (last init byte)
    localparam int MODE_MASTER_BIT  = 2;
    localparam int MODE_AUTOEOI_BIT = 1;
    localparam int MODE_CALL_BIT    = 0;

    // poll result layout
    localparam int         POLL_FLAG_BIT  = 7;
    localparam logic [2:0] POLL_NONE_CODE = 3'h7;

    // reset values
    localparam logic [7:0] LEVELS_RESET = 8'h00;
    localparam logic [4:0] VBASE_RESET  = 5'h00;
    localparam logic [2:0] ID_RESET     = 3'h0;
    localparam logic [2:0] CAS_DEFAULT  = 3'h0;

    // initialization progress
    typedef enum logic [3:0] {
        IRQSP_INIT_DONE  = 4'b0001,
        IRQSP_INIT_VBASE = 4'b0010,
        IRQSP_INIT_CASC  = 4'b0100,
        IRQSP_INIT_MODE  = 4'b1000
    } irqsp_init_e;

    // acknowledge sequence phase
    typedef enum logic [2:0] {
        IRQSP_ACK_IDLE   = 3'b001,
        IRQSP_ACK_FIRST  = 3'b010,
        IRQSP_ACK_SECOND = 3'b100
    } irqsp_ack_e;

    // pins that cross into the clock domain
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       cs;
        logic [1:0] addr;
        logic       ack;
        logic [7:0] req;
        logic [7:0] wdata;
        logic [2:0] cas;
    } irqsp_pins_s;

    // whole controller state
    typedef struct packed {
        logic [7:0]  pending_request_levels;
        logic [7:0]  in_service_levels;
        logic [7:0]  level_mask;
        logic [4:0]  vbase;
        logic [7:0]  slave_map;
        logic [2:0]  slave_id;
        logic        is_master;
        logic        auto_eoi;
        logic        call_mode;
        logic        level_mode;
        logic        sel_isr;
        logic        poll_pend;
        irqsp_init_e init;
        irqsp_ack_e  ack;
        logic [2:0]  ack_level;
        logic        ack_valid;
        logic [7:0]  dout;
        logic        dout_oe;
        logic        buf_en;
        logic        int_out;
        logic [2:0]  cas_out;
        logic        cas_oe;
    } irqsp_state_s;

endpackage : irqsp_pkg

// *** hw/irqsp_sync.sv ***
/*
 * irqsp_sync: two-flop synchroniser with a rising-edge flag per bit.
 * Assumes inputs are asynchronous to clk; reset is synchronous.
 */
`timescale 1ns/1ps
module irqsp_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out,
    output logic      [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
        logic [W-1:0] prev;
    } irqsp_sync_s;

    irqsp_sync_s st;
    irqsp_sync_s next_st;

    // first stage feeds only the second
    always_comb
    begin
        next_st        = st;
        next_st.meta   = async_in;
        next_st.stable = st.meta;
        next_st.prev   = st.stable;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st <= '0;
        else
            st <= next_st;
    end

    assign sync_out = st.stable;
    assign rise     = st.stable & ~st.prev;

endmodule : irqsp_sync

// *** hw/irqsp_controller.sv ***
/*
 * irqsp_controller: eight-level priority interrupt controller with
 * register readback, poll and master/slave cascade.
 * Assumes bus strobes, address, data and request pins are asynchronous
 * and held stable while a strobe is high; tri-state wiring is external.
 */
`timescale 1ns/1ps

module irqsp_controller #(
    parameter logic       UNIT_IS_SLAVE = 1'b0,
    parameter logic [7:0] CALL_OPCODE   = 8'h00
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       chip_select,
    input  wire logic [1:0] port_addr,
    input  wire logic       rd_strobe,
    input  wire logic       wr_strobe,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data,
    output logic            rd_data_oe,
    input  wire logic [7:0] request_input,
    input  wire logic       interrupt_acknowledge_pulse,
    output logic            int_out,
    input  wire logic [2:0] cascade_in,
    output logic      [2:0] cascade_out,
    output logic            cascade_oe,
    output logic            buffer_enable_output
);
    irqsp_pkg::irqsp_state_s st;
    irqsp_pkg::irqsp_state_s next_st;
    irqsp_pkg::irqsp_pins_s  pin_async;
    irqsp_pkg::irqsp_pins_s  pin;
    irqsp_pkg::irqsp_pins_s  pin_rise;

    // lowest set bit wins; index 0 is the highest priority
    function automatic logic [3:0] irqsp_top_level(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h8;
        for (int i = 7; i >= 0; i--)
        begin
            if (v[i])
                r = 4'(i);
        end
        return r;
    endfunction : irqsp_top_level

    // every pin passes two flops before use
    assign pin_async = '{rd:    rd_strobe,
                         wr:    wr_strobe,
                         cs:    chip_select,
                         addr:  port_addr,
                         ack:   interrupt_acknowledge_pulse,
                         req:   request_input,
                         wdata: wr_data,
                         cas:   cascade_in};

    irqsp_sync #(
        .W ($bits(irqsp_pkg::irqsp_pins_s))
    ) u_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (pin_async),
        .sync_out (pin),
        .rise     (pin_rise)
    );

    logic       sel_unit;
    logic       sel_high;
    logic       rd_go;
    logic       wr_go;
    logic [7:0] pend;
    logic [3:0] pend_top;
    logic [3:0] isr_top;
    logic       req_ok;
    logic [7:0] req_edge;
    logic [7:0] poll_word;
    logic [2:0] ack_lvl;
    logic       own_vector;
    logic [7:0] wd;
    logic       poll_cmd;

    // unit and register select from the port offset
    assign sel_unit = pin.addr[irqsp_pkg::PORT_UNIT_BIT] == UNIT_IS_SLAVE;
    assign sel_high = pin.addr[irqsp_pkg::PORT_SEL_BIT];
    assign rd_go    = pin_rise.rd & pin.cs & sel_unit;
    assign wr_go    = pin_rise.wr & pin.cs & sel_unit;
    assign wd       = pin.wdata;
    assign req_edge = pin_rise.req;

    // a poll command landing with a poll read keeps the new poll armed
    assign poll_cmd = wr_go && !sel_high && !wd[irqsp_pkg::CMD_INIT_BIT]
                      && wd[irqsp_pkg::CMD_OPER_BIT]
                      && wd[irqsp_pkg::CMD_POLL_BIT];

    // fully nested priority: pending must outrank in-service
    assign pend     = st.pending_request_levels & ~st.level_mask;
    assign pend_top = irqsp_top_level(pend);
    assign isr_top  = irqsp_top_level(st.in_service_levels);
    assign req_ok   = (pend_top != 4'h8) && (pend_top < isr_top);

    // poll byte with flag and level code
    always_comb
    begin
        poll_word = 8'h00;
        if (req_ok)
        begin
            poll_word[irqsp_pkg::POLL_FLAG_BIT] = 1'b1;
            poll_word[2:0] = pend_top[2:0];
        end
        else
            poll_word[2:0] = irqsp_pkg::POLL_NONE_CODE;
    end

    // vector owner on second pulse
    assign ack_lvl    = st.ack_level;
    assign own_vector = st.is_master ? !st.slave_map[ack_lvl]
                                     : (pin.cas == st.slave_id) && st.ack_valid;

    // next-state logic of the whole controller
    always_comb
    begin
        next_st = st;

        // request latch: level mode follows, edge mode catches rises
        if (st.level_mode)
            next_st.pending_request_levels = pin.req;
        else
            next_st.pending_request_levels = (st.pending_request_levels & pin.req) | req_edge;

        // register writes from the processor
        if (wr_go)
        begin
            if (!sel_high && wd[irqsp_pkg::CMD_INIT_BIT])
            begin
                next_st.in_service_levels        = irqsp_pkg::LEVELS_RESET;
                next_st.level_mask        = irqsp_pkg::LEVELS_RESET;
                next_st.pending_request_levels        = irqsp_pkg::LEVELS_RESET;
                next_st.sel_isr    = 1'b0;
                next_st.poll_pend  = 1'b0;
                next_st.level_mode = wd[irqsp_pkg::INIT_LEVEL_BIT];
                next_st.init       = irqsp_pkg::IRQSP_INIT_VBASE;
            end
            else if (!sel_high && wd[irqsp_pkg::CMD_OPER_BIT])
            begin
                if (wd[irqsp_pkg::CMD_POLL_BIT])
                    next_st.poll_pend = 1'b1;
                if (wd[irqsp_pkg::CMD_RSEL_EN_BIT])
                    next_st.sel_isr = wd[irqsp_pkg::CMD_RSEL_ISR_BIT];
            end
            else if (!sel_high && wd[irqsp_pkg::CMD_EOI_BIT])
            begin
                if (wd[irqsp_pkg::CMD_SPEC_BIT])
                    next_st.in_service_levels[wd[2:0]] = 1'b0;
                else if (isr_top != 4'h8)
                    next_st.in_service_levels[isr_top[2:0]] = 1'b0;
            end
            else if (sel_high)
            begin
                case (st.init)
                    irqsp_pkg::IRQSP_INIT_VBASE:
                    begin
                        next_st.vbase = wd[7:3];
                        next_st.init  = irqsp_pkg::IRQSP_INIT_CASC;
                    end
                    irqsp_pkg::IRQSP_INIT_CASC:
                    begin
                        // one slave per master input, eight at most
                        next_st.slave_map = wd;
                        next_st.slave_id  = wd[2:0];
                        next_st.init      = irqsp_pkg::IRQSP_INIT_MODE;
                    end
                    irqsp_pkg::IRQSP_INIT_MODE:
                    begin
                        next_st.is_master = wd[irqsp_pkg::MODE_MASTER_BIT];
                        next_st.auto_eoi  = wd[irqsp_pkg::MODE_AUTOEOI_BIT];
                        next_st.call_mode = wd[irqsp_pkg::MODE_CALL_BIT];
                        next_st.init      = irqsp_pkg::IRQSP_INIT_DONE;
                    end
                    default:
                        next_st.level_mask = wd;
                endcase
            end
        end

        // register reads; data stands while the strobe is high
        if (rd_go)
        begin
            next_st.dout_oe = 1'b1;
            if (st.poll_pend)
            begin
                next_st.dout      = poll_word;
                next_st.poll_pend = poll_cmd;
                if (req_ok)
                begin
                    next_st.in_service_levels[pend_top[2:0]] = 1'b1;
                    if (!st.level_mode)
                        next_st.pending_request_levels[pend_top[2:0]] = 1'b0;
                end
            end
            else if (sel_high)
                next_st.dout = st.level_mask;
            else if (st.sel_isr)
                next_st.dout = st.in_service_levels;
            else
                next_st.dout = st.pending_request_levels;
        end
        else if (!pin.rd && st.ack == irqsp_pkg::IRQSP_ACK_IDLE)
            next_st.dout_oe = 1'b0;

        // acknowledge sequence
        case (st.ack)
            irqsp_pkg::IRQSP_ACK_IDLE:
            begin
                if (pin_rise.ack)
                begin
                    next_st.ack       = irqsp_pkg::IRQSP_ACK_FIRST;
                    // no request at acknowledge answers as level seven
                    next_st.ack_valid = req_ok;
                    next_st.ack_level = req_ok ? pend_top[2:0]
                                               : irqsp_pkg::POLL_NONE_CODE;
                    if (st.is_master)
                    begin
                        if (req_ok)
                        begin
                            next_st.in_service_levels[pend_top[2:0]] = 1'b1;
                            if (!st.level_mode)
                                next_st.pending_request_levels[pend_top[2:0]] = 1'b0;
                        end
                        // slave id or default zero
                        next_st.cas_oe  = 1'b1;
                        next_st.cas_out = (req_ok && st.slave_map[pend_top[2:0]])
                                          ? pend_top[2:0]
                                          : irqsp_pkg::CAS_DEFAULT;
                        if (st.call_mode)
                        begin
                            next_st.dout    = CALL_OPCODE;
                            next_st.dout_oe = 1'b1;
                            next_st.buf_en  = 1'b1;
                        end
                    end
                end
            end
            irqsp_pkg::IRQSP_ACK_FIRST:
            begin
                if (!pin.ack)
                begin
                    next_st.dout_oe = 1'b0;
                    next_st.buf_en  = 1'b0;
                end
                if (pin_rise.ack)
                begin
                    next_st.ack = irqsp_pkg::IRQSP_ACK_SECOND;
                    if (own_vector)
                    begin
                        next_st.dout    = {st.vbase, ack_lvl};
                        next_st.dout_oe = 1'b1;
                        next_st.buf_en  = 1'b1;
                        if (!st.is_master)
                        begin
                            next_st.in_service_levels[ack_lvl] = 1'b1;
                            if (!st.level_mode)
                                next_st.pending_request_levels[ack_lvl] = 1'b0;
                        end
                    end
                end
            end
            irqsp_pkg::IRQSP_ACK_SECOND:
            begin
                if (!pin.ack)
                begin
                    next_st.ack     = irqsp_pkg::IRQSP_ACK_IDLE;
                    next_st.dout_oe = 1'b0;
                    next_st.buf_en  = 1'b0;
                    next_st.cas_oe  = 1'b0;
                    next_st.cas_out = irqsp_pkg::CAS_DEFAULT;
                    if (st.auto_eoi && st.ack_valid)
                        next_st.in_service_levels[ack_lvl] = 1'b0;
                end
            end
            default:
                next_st.ack = irqsp_pkg::IRQSP_ACK_IDLE;
        endcase

        // interrupt output only when outranking
        next_st.int_out = req_ok
                          && st.init == irqsp_pkg::IRQSP_INIT_DONE
                          && st.ack == irqsp_pkg::IRQSP_ACK_IDLE;
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st            <= '0;
            st.pending_request_levels        <= irqsp_pkg::LEVELS_RESET;
            st.in_service_levels        <= irqsp_pkg::LEVELS_RESET;
            st.level_mask        <= irqsp_pkg::LEVELS_RESET;
            st.vbase      <= irqsp_pkg::VBASE_RESET;
            st.slave_id   <= irqsp_pkg::ID_RESET;
            st.init       <= irqsp_pkg::IRQSP_INIT_DONE;
            st.ack        <= irqsp_pkg::IRQSP_ACK_IDLE;
            st.cas_out    <= irqsp_pkg::CAS_DEFAULT;
        end
        else
            st <= next_st;
    end

    // outputs straight from state flops
    assign rd_data              = st.dout;
    assign rd_data_oe           = st.dout_oe;
    assign int_out              = st.int_out;
    assign cascade_out          = st.cas_out;
    assign cascade_oe           = st.cas_oe;
    assign buffer_enable_output = st.buf_en;

endmodule : irqsp_controller

// *** test/irqsp_checker_assertions.sv ***
/*
 * irqsp_checker: port-level assertions on irqsp_controller.
 * Assumes strobes and acknowledge pulses are held for three or more cycles.
 */
`timescale 1ns/1ps
module irqsp_checker #(
    parameter logic UNIT_IS_SLAVE = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       chip_select,
    input  wire logic [1:0] port_addr,
    input  wire logic       rd_strobe,
    input  wire logic       interrupt_acknowledge_pulse,
    input  wire logic [7:0] request_input,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_data_oe,
    input  wire logic       int_out,
    input  wire logic       cascade_oe,
    input  wire logic       buffer_enable_output
);
    logic ack;

    // short alias for the acknowledge pin
    assign ack = interrupt_acknowledge_pulse;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_oe_cause: assert property (
        $rose(rd_data_oe) |-> $past(rd_strobe, 2) || $past(ack, 2))
        else $error("data driven without a read or acknowledge");
    a_oe_release: assert property (
        (!rd_strobe && !ack) [*6] |-> !rd_data_oe)
        else $error("data still driven after strobes fell");
    a_unit_select: assert property (
        $rose(rd_data_oe) && !$past(ack, 2) |-> $past(chip_select, 2)
        && $past(port_addr[1], 2) == UNIT_IS_SLAVE)
        else $error("read answered for another unit");
    a_rd_stable: assert property (
        rd_data_oe && $past(rd_data_oe) && rd_strobe |-> $stable(rd_data))
        else $error("read byte changed during a read");
    a_buf_cause: assert property (
        $rose(buffer_enable_output) |-> $past(ack, 2))
        else $error("buffer enabled outside acknowledge");
    a_buf_drive: assert property (
        buffer_enable_output |-> rd_data_oe)
        else $error("buffer enabled with no byte driven");
    a_cas_cause: assert property (
        $rose(cascade_oe) |-> $past(ack, 2))
        else $error("cascade driven outside acknowledge");
    a_cas_release: assert property (
        (!ack) [*8] |-> !cascade_oe)
        else $error("cascade lines not released");
    a_int_cause: assert property (
        $rose(int_out) |-> $past(request_input) != 8'h00)
        else $error("interrupt raised with no request");
endmodule : irqsp_checker

bind irqsp_controller irqsp_checker #(.UNIT_IS_SLAVE(UNIT_IS_SLAVE)) i_chk (
    .clk                        (clk),
    .srst                       (srst),
    .chip_select                (chip_select),
    .port_addr                  (port_addr),
    .rd_strobe                  (rd_strobe),
    .interrupt_acknowledge_pulse(interrupt_acknowledge_pulse),
    .request_input              (request_input),
    .rd_data                    (rd_data),
    .rd_data_oe                 (rd_data_oe),
    .int_out                    (int_out),
    .cascade_oe                 (cascade_oe),
    .buffer_enable_output       (buffer_enable_output)
);

// *** test/irqsp_slave_model.sv ***
/*
 * irqsp_slave_model: behavioural cascaded slave on a master input.
 * Assumes the bench raises its request and the master drives cascade.
 */
`timescale 1ns/1ps
module irqsp_slave_model #(
    parameter logic [2:0] SLAVE_ID = irqsp_pkg::ONBOARD_SLAVE_LEVEL
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       raise,
    input  wire logic [2:0] cascade_out,
    input  wire logic       cascade_oe,
    output logic            slave_int,
    output logic      [2:0] seen_cas
);
    logic served;

    // request held until the master addresses this identifier
    always_ff @(posedge clk)
    begin
        if (srst || !raise)
        begin
            slave_int <= 1'b0;
            served    <= 1'b0;
            seen_cas  <= 3'h0;
        end
        else if (cascade_oe && cascade_out == SLAVE_ID)
        begin
            slave_int <= 1'b0;
            served    <= 1'b1;
            seen_cas  <= cascade_out;
        end
        else
            slave_int <= !served;
    end
endmodule : irqsp_slave_model

// *** test/tb_top.sv ***
/*
 * tb_top: self-checking bench for the master irqsp_controller unit.
 * Assumes the partner slave model and the bound checker.
 */
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] CALL_OP = 8'h5a; // arbitrary opcode
    localparam logic [7:0] VB      = 8'h40; // vector base byte
    logic       clk;
    logic       srst;
    logic       chip_select;
    logic [1:0] port_addr;
    logic       rd_strobe;
    logic       wr_strobe;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic       rd_data_oe;
    logic [7:0] bench_req;
    logic [7:0] request_input;
    logic       ack;
    logic       int_out;
    logic [2:0] cascade_out;
    logic       cascade_oe;
    logic       buffer_enable_output;
    logic       slave_raise;
    logic       slave_int;
    logic [2:0] seen_cas;
    logic [7:0] q;
    logic       oe;
    logic [3:0] cas_q;
    logic [7:0] r;
    int         failures;
    int         num_checks;

    // slave output lands on master input one
    assign request_input = {bench_req[7:2], slave_int, bench_req[0]};

    always #20 clk = ~clk;

    irqsp_controller #(.UNIT_IS_SLAVE(1'b0), .CALL_OPCODE(CALL_OP))
    i_irqsp_controller (
        .clk                        (clk),
        .srst                       (srst),
        .chip_select                (chip_select),
        .port_addr                  (port_addr),
        .rd_strobe                  (rd_strobe),
        .wr_strobe                  (wr_strobe),
        .wr_data                    (wr_data),
        .rd_data                    (rd_data),
        .rd_data_oe                 (rd_data_oe),
        .request_input              (request_input),
        .interrupt_acknowledge_pulse(ack),
        .int_out                    (int_out),
        .cascade_in                 (3'h0),
        .cascade_out                (cascade_out),
        .cascade_oe                 (cascade_oe),
        .buffer_enable_output       (buffer_enable_output)
    );

    irqsp_slave_model i_irqsp_slave_model (
        .clk        (clk),
        .srst       (srst),
        .raise      (slave_raise),
        .cascade_out(cascade_out),
        .cascade_oe (cascade_oe),
        .slave_int  (slave_int),
        .seen_cas   (seen_cas)
    );

    // highest priority level as a poll byte
    function automatic logic [7:0] poll_word(input logic [7:0] v);
        poll_word = 8'h07;
        for (int i = 7; i >= 0; i--)
            if (v[i])
                poll_word = 8'h80 | 8'(i);
    endfunction : poll_word

    // in-service bit of the highest priority request
    function automatic logic [7:0] low_bit(input logic [7:0] v);
        low_bit = v & (~v + 8'h01);
    endfunction : low_bit

    task automatic tally_and_finish();
        if (failures == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
        end
    endtask : check

    // one bus cycle; strobes held six cycles to cover the sync latency
    task automatic bus(input logic w, input logic [1:0] a,
                       input logic [7:0] d);
        @(negedge clk);
        chip_select = 1'b1;
        port_addr   = a;
        wr_data     = d;
        repeat (4) @(negedge clk);
        wr_strobe = w;
        rd_strobe = !w;
        repeat (6) @(negedge clk);
        q         = rd_data;
        oe        = rd_data_oe;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        repeat (6) @(negedge clk);
        chip_select = 1'b0;
    endtask : bus

    // one acknowledge pulse, sampling what the master drives
    task automatic pulse();
        @(negedge clk);
        ack = 1'b1;
        repeat (6) @(negedge clk);
        q     = rd_data;
        oe    = buffer_enable_output;
        cas_q = {cascade_oe, cascade_out};
        ack   = 1'b0;
        repeat (6) @(negedge clk);
    endtask : pulse

    // master, input one slaved, call mode, edge mode
    task automatic init();
        bus(1'b1, 2'h0, 8'h10);
        bus(1'b1, 2'h1, VB);
        bus(1'b1, 2'h1, 8'h02);
        bus(1'b1, 2'h1, 8'h05);
    endtask : init

    task automatic wait_int();
        for (int i = 0; i < 40 && int_out !== 1'b1; i++)
            @(negedge clk);
        if (int_out !== 1'b1)
        begin
            failures++;
            $display("CHECK FAILED t=%0t no interrupt", $time);
            tally_and_finish();
        end
    endtask : wait_int

    // hang guard
    initial
    begin
        #2000000;
        failures++;
        $display("CHECK FAILED t=%0t hang guard expired", $time);
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        clk         = 1'b0;
        srst        = 1'b1;
        chip_select = 1'b0;
        port_addr   = 2'h0;
        rd_strobe   = 1'b0;
        wr_strobe   = 1'b0;
        wr_data     = 8'h00;
        bench_req   = 8'h00;
        ack         = 1'b0;
        slave_raise = 1'b0;
        failures    = 0;
        num_checks  = 0;
        r           = 8'($urandom(32'h17c8));
        repeat (8) @(negedge clk);
        srst = 1'b0;
        bus(1'b0, 2'h0, 8'h00);
        check(q, 8'h00);
        bus(1'b0, 2'h1, 8'h00);
        check(q, 8'h00);
        init();
        bus(1'b1, 2'h0, 8'h0c);
        bus(1'b0, 2'h0, 8'h00);
        check(q, poll_word(8'h00));
        bus(1'b0, 2'h0, 8'h00);
        check(q, 8'h00);
        r = 8'($urandom);
        bus(1'b1, 2'h1, r);
        bus(1'b0, 2'h1, 8'h00);
        check(q, r);
        bus(1'b0, 2'h2, 8'h00);
        check({7'h0, oe}, 8'h00);
        repeat (3)
        begin
            init();
            r         = (8'($urandom) & 8'hfd) | 8'h80;
            bench_req = r;
            wait_int();
            bus(1'b0, 2'h0, 8'h00);
            check(q, r);
            bus(1'b1, 2'h0, 8'h0c);
            bus(1'b0, 2'h0, 8'h00);
            check(q, poll_word(r));
            bus(1'b1, 2'h0, 8'h0b);
            bus(1'b0, 2'h0, 8'h00);
            check(q, low_bit(r));
            bus(1'b0, 2'h0, 8'h00);
            check(q, low_bit(r));
            bus(1'b1, 2'h0, 8'h20);
            bench_req = 8'h00;
        end
        init();
        bench_req = 8'h08;
        wait_int();
        pulse();
        check({4'h0, cas_q}, 8'h08);
        check(q, CALL_OP);
        pulse();
        check(q, {VB[7:3], 3'h3});
        check({7'h0, oe}, 8'h01);
        bus(1'b1, 2'h0, 8'h0b);
        bus(1'b0, 2'h0, 8'h00);
        check(q, 8'h08);
        bus(1'b1, 2'h0, 8'h20);
        bench_req   = 8'h00;
        slave_raise = 1'b1;
        wait_int();
        pulse();
        check({4'h0, cas_q}, 8'h09);
        check({5'h0, seen_cas}, 8'h01);
        pulse();
        bus(1'b0, 2'h0, 8'h00);
        check(q, 8'h02);
        bus(1'b1, 2'h0, 8'h61);
        bus(1'b0, 2'h0, 8'h00);
        check(q, 8'h00);
        bus(1'b1, 2'h0, 8'h18);
        bus(1'b1, 2'h1, VB);
        bus(1'b1, 2'h1, 8'h02);
        bus(1'b1, 2'h1, 8'h06);
        bench_req = 8'h08;
        wait_int();
        pulse();
        check({7'h0, oe}, 8'h00);
        check({4'h0, cas_q}, 8'h08);
        pulse();
        check(q, {VB[7:3], 3'h3});
        bus(1'b1, 2'h0, 8'h0b);
        bus(1'b0, 2'h0, 8'h00);
        check(q, 8'h00);
        bus(1'b1, 2'h0, 8'h0a);
        bus(1'b0, 2'h0, 8'h00);
        check(q, 8'h08);
        bench_req   = 8'h00;
        slave_raise = 1'b0;
        srst        = 1'b1;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        bus(1'b0, 2'h0, 8'h00);
        check(q, 8'h00);
        tally_and_finish();
    end
endmodule : tb_top
